/* output_rail_defs.svh */
`ifndef OUTPUT_RAIL_DEFS_SVH
`define OUTPUT_RAIL_DEFS_SVH

// Bus address of this device (arbitrary value)
`define DEVICE_ADDRESS      7'h50

// Register offsets
`define ADDR_SYSTEM_RAIL    8'h06
`define ADDR_AUX_OUTPUT     8'h07
`define ADDR_PUSH_BUTTON    8'h08

// Reset values and writable bit masks
`define RESET_SYSTEM_RAIL   8'haa
`define RESET_AUX_OUTPUT    8'h28
`define RESET_PUSH_BUTTON   8'h68
`define WMASK_SYSTEM_RAIL   8'hfe
`define WMASK_AUX_OUTPUT    8'hfd
`define WMASK_PUSH_BUTTON   8'hfc

// System rail fields
`define SYS_EN_BIT          7
`define BUCK_RANGE_SELECT_HI          6
`define BUCK_RANGE_SELECT_LO          5
`define SYS_CODE_HI         4
`define SYS_CODE_LO         1

// Auxiliary output fields
`define AUX_EN_BIT          7
`define AUX_CODE_HI         6
`define AUX_CODE_LO         2
`define AUX_QUAL_BIT        0

// Push-button fields
`define PB_SHORT_SEL_BIT    7
`define PB_LONG_SEL_BIT     6
`define PB_RECOVER_BIT      5
`define PB_RTIME_HI         4
`define PB_RTIME_LO         3
`define PB_PGMR_BIT         2
`define PB_SHORT_STAT_BIT   1
`define PB_LONG_STAT_BIT    0

// Range select codes
`define RANGE_LOW_TABLE     2'h0
`define RANGE_LINEAR_LOW    2'h1
`define RANGE_MID_TABLE     2'h2
`define RANGE_LINEAR_HIGH   2'h3
`define MID_TABLE_OFFSET    5'h05

// Voltages in millivolts
`define BUCK_BASE_LOW_MV    12'h514
`define BUCK_BASE_HIGH_MV   12'h708
`define STEP_MV             12'h064
`define AUX_BASE_MV         12'h320
`define AUX_PASS_LIMIT_MV   12'hce4

// Timing
`define CLOCK_PERIOD_NS     5
`define TICK_PERIOD_NS      1000000
`define SHORT_FAST_MS       14'h0050
`define SHORT_SLOW_MS       14'h0258
`define LONG_FAST_MS        14'h03e8
`define LONG_SLOW_MS        14'h05dc
`define RESET_5S_MS         14'h1388
`define RESET_9S_MS         14'h2328
`define RESET_11S_MS        14'h2af8
`define RESET_15S_MS        14'h3a98
`define HOLD_MAX_MS         14'h3fff

`endif

/* output_rail_pkg.sv */
`default_nettype none
package output_rail_pkg;

    // Register write carried from the serial port
    typedef struct packed {
        logic       strobe;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_type;

    // Read access: address being read and a pulse when a byte is taken
    typedef struct packed {
        logic       taken;
        logic [7:0] addr;
    } reg_read_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_POINTER,
        ST_WRITE,
        ST_READ
    } serial_state_type;

endpackage
`default_nettype wire

/* serial_register_port.sv */
`include "output_rail_defs.svh"
`default_nettype none
module serial_register_port (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          resetn,
    // Serial pins
    input  wire logic                          scl,
    input  wire logic                          sda_in,
    output var  logic                          sda_oe,
    // Register side
    output var output_rail_pkg::reg_write_type wr,
    output var output_rail_pkg::reg_read_type  rd,
    input  wire logic [7:0]                    rdata
);
    import output_rail_pkg::*;

    logic [1:0]       scl_sync;
    logic [1:0]       sda_sync;
    logic             scl_prev;
    logic             sda_prev;
    logic             scl_rise;
    logic             scl_fall;
    logic             start_seen;
    logic             stop_seen;
    serial_state_type state;
    logic [3:0]       bit_count;
    logic             ack_phase;
    logic [7:0]       shift;
    logic [7:0]       tx_byte;
    logic [7:0]       pointer;

    // Synchronisers and edge history
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl};
            sda_sync <= {sda_sync[0], sda_in};
            scl_prev <= scl_sync[1];
            sda_prev <= sda_sync[1];
        end
    end

    // Bus conditions
    assign scl_rise   = scl_sync[1] & ~scl_prev;
    assign scl_fall   = ~scl_sync[1] & scl_prev;
    assign start_seen = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
    assign stop_seen  = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];

    // Byte framing, acknowledge and register pointer
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state     <= ST_IDLE;
            bit_count <= 4'h0;
            ack_phase <= 1'b0;
            shift     <= 8'h00;
            tx_byte   <= 8'h00;
            pointer   <= 8'h00;
            sda_oe    <= 1'b0;
            wr        <= '0;
            rd        <= '0;
        end else begin
            wr.strobe <= 1'b0;
            rd.taken  <= 1'b0;
            rd.addr   <= pointer; // Lags the pointer by one cycle, reads come much later
            if (start_seen) begin
                state     <= ST_ADDR;
                bit_count <= 4'h0;
                ack_phase <= 1'b0;
                sda_oe    <= 1'b0;
            end else if (stop_seen) begin
                state  <= ST_IDLE;
                sda_oe <= 1'b0;
            end else if (state != ST_IDLE && scl_rise) begin
                if (ack_phase) begin
                    if (state == ST_READ && sda_sync[1]) begin
                        state <= ST_IDLE; // Master refused more data
                    end
                end else if (bit_count < 4'h8) begin
                    shift     <= {shift[6:0], sda_sync[1]};
                    bit_count <= bit_count + 4'h1;
                end
            end else if (state != ST_IDLE && scl_fall) begin
                if (ack_phase) begin
                    ack_phase <= 1'b0;
                    bit_count <= 4'h0;
                    if (state == ST_READ) begin
                        tx_byte  <= rdata;
                        sda_oe   <= ~rdata[7];
                        rd.taken <= 1'b1;
                        pointer  <= pointer + 8'h01;
                    end else begin
                        sda_oe <= 1'b0;
                    end
                end else if (bit_count == 4'h8) begin
                    ack_phase <= 1'b1;
                    sda_oe    <= 1'b1;
                    case (state)
                        ST_ADDR: begin
                            if (shift[7:1] != `DEVICE_ADDRESS) begin
                                state  <= ST_IDLE;
                                sda_oe <= 1'b0;
                            end else if (shift[0]) begin
                                state <= ST_READ;
                            end else begin
                                state <= ST_POINTER;
                            end
                        end
                        ST_POINTER: begin
                            pointer <= shift;
                            state   <= ST_WRITE;
                        end
                        ST_WRITE: begin
                            wr.strobe <= 1'b1;
                            wr.addr   <= pointer;
                            wr.data   <= shift;
                            pointer   <= pointer + 8'h01;
                        end
                        ST_READ: begin
                            sda_oe <= 1'b0; // Master drives its acknowledge
                        end
                        default: begin
                            sda_oe <= 1'b0;
                        end
                    endcase
                end else if (state == ST_READ) begin
                    sda_oe <= ~tx_byte[3'h7 - bit_count[2:0]];
                end
            end
        end
    end

endmodule
`default_nettype wire

/* output_rail_config_regs.sv */
// Behaviour
// - A clear buck enable bit stops the buck and pulls it low.
// - The range select picks one of four buck spans.
// - Linear-range code bits weigh 800, 400, 200 and 100 mV.
// - Range 01 gives 1.30 V plus code times 100 mV.
// - Range 11 gives 1.80 V plus code times 100 mV.
// - Ranges 00 and 10 map the code through a fixed table.
// - The aux target is 0.8 V plus code times 100 mV.
// - An aux code above 3.3 V selects pass-through.
// - A new aux level applies only while bit and pin hold it off.
// - The aux enable bit or the control pin switches it on; reset is off, code 01010.
// - A button reset follows its hold time, qualified by input supply.
// - The button register resets to 011010 above two status bits.
// - Wake status bits set on their hold times and clear once read.
// - Bits 4:3 pick a 5, 9, 11 or 15 second reset hold.
`include "output_rail_defs.svh"
`default_nettype none
module output_rail_config_regs #(
    parameter int TICK_CYCLES = `TICK_PERIOD_NS / `CLOCK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RESETN,
    // Serial management bus
    input  wire logic        SCL,
    input  wire logic        SDA_IN,
    output var  logic        SDA_OUT,
    output var  logic        SDA_OE,
    // External pins
    input  wire logic        PUSH_BUTTON_INPUT_N,
    input  wire logic        AUX_CONTROL_PIN,
    input  wire logic        VIN_VALID,
    // Buck rail control
    output var  logic        BUCK_ENABLE,
    output var  logic        BUCK_PULL_LOW,
    output var  logic [11:0] BUCK_TARGET_MV,
    // Auxiliary output control
    output var  logic        AUX_OUTPUT_ON,
    output var  logic        AUX_PASS_THROUGH,
    output var  logic [11:0] AUX_TARGET_MV,
    // Push-button results
    output var  logic        BUTTON_RESET,
    output var  logic        RECOVER_TO_HIGH_Z,
    output var  logic        STATUS_PIN_AS_BUTTON
);
    import output_rail_pkg::*;

    reg_write_type wr;
    reg_read_type  rd;
    logic [7:0]    rdata;
    logic [7:0]    system_rail_control;
    logic [7:0]    aux_output_control;
    logic [7:0]    push_button_control;
    logic          short_press_status;
    logic          long_press_status;
    logic [4:0]    aux_level_applied;
    logic [2:0]    pin_meta;
    logic [2:0]    pin_sync;
    logic          button_pressed;
    logic          aux_pin_on;
    logic          vin_ok;
    logic [17:0]   tick_count;
    logic          tick;
    logic [13:0]   hold_ms;
    logic [13:0]   next_hold_ms;
    logic          reset_issued;
    logic          short_hit;
    logic          long_hit;
    logic          reset_due;
    logic          status_read;
    logic [11:0]   next_buck_mv;
    logic [11:0]   next_aux_mv;

    // Table ranges; range 10 starts at entry 5
    function automatic logic [11:0] table_mv(input logic [4:0] index);
        case (index)
            5'h00:   table_mv = 12'h44c;
            5'h01:   table_mv = 12'h4b0;
            5'h02:   table_mv = 12'h4e2;
            5'h03:   table_mv = 12'h535;
            5'h04:   table_mv = 12'h589;
            5'h05:   table_mv = 12'h5dc;
            5'h06:   table_mv = 12'h62f;
            5'h07:   table_mv = 12'h683;
            5'h08:   table_mv = 12'h6d6;
            5'h09:   table_mv = 12'h729;
            5'h0a:   table_mv = 12'h77d;
            5'h0b:   table_mv = 12'h7d0;
            5'h0c:   table_mv = 12'h823;
            5'h0d:   table_mv = 12'h877;
            5'h0e:   table_mv = 12'h8ca;
            5'h0f:   table_mv = 12'h91d;
            5'h10:   table_mv = 12'h971;
            5'h11:   table_mv = 12'h9c4;
            5'h12:   table_mv = 12'ha17;
            5'h13:   table_mv = 12'ha6b;
            default: table_mv = 12'habe;
        endcase
    endfunction

    // Hold time selected by the reset time field
    function automatic logic [13:0] reset_hold_ms(input logic [1:0] code);
        case (code)
            2'h0:    reset_hold_ms = `RESET_5S_MS;
            2'h1:    reset_hold_ms = `RESET_9S_MS;
            2'h2:    reset_hold_ms = `RESET_11S_MS;
            default: reset_hold_ms = `RESET_15S_MS;
        endcase
    endfunction

    serial_register_port port (
        .clock  (CLOCK),
        .resetn (RESETN),
        .scl    (SCL),
        .sda_in (SDA_IN),
        .sda_oe (SDA_OE),
        .wr     (wr),
        .rd     (rd),
        .rdata  (rdata)
    );

    // Open-drain data pin only ever pulls low
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            SDA_OUT <= 1'b0;
        end else begin
            SDA_OUT <= 1'b0;
        end
    end

    // Pin synchronisers
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            pin_meta <= 3'h1;
            pin_sync <= 3'h1;
        end else begin
            pin_meta <= {VIN_VALID, AUX_CONTROL_PIN, PUSH_BUTTON_INPUT_N};
            pin_sync <= pin_meta;
        end
    end

    assign button_pressed = ~pin_sync[0];
    assign aux_pin_on     = pin_sync[1];
    assign vin_ok         = pin_sync[2];

    // Register writes, read-only bits masked
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            system_rail_control <= `RESET_SYSTEM_RAIL;
            aux_output_control  <= `RESET_AUX_OUTPUT;
            push_button_control <= `RESET_PUSH_BUTTON;
        end else if (wr.strobe) begin
            if (wr.addr == `ADDR_SYSTEM_RAIL) begin
                system_rail_control <= wr.data & `WMASK_SYSTEM_RAIL;
            end else if (wr.addr == `ADDR_AUX_OUTPUT) begin
                aux_output_control <= wr.data & `WMASK_AUX_OUTPUT;
            end else if (wr.addr == `ADDR_PUSH_BUTTON) begin
                push_button_control <= wr.data & `WMASK_PUSH_BUTTON;
            end
        end
    end

    // Read data; unmapped offsets read zero
    always_comb begin
        if (rd.addr == `ADDR_SYSTEM_RAIL) begin
            rdata = system_rail_control;
        end else if (rd.addr == `ADDR_AUX_OUTPUT) begin
            rdata = aux_output_control;
        end else if (rd.addr == `ADDR_PUSH_BUTTON) begin
            rdata = push_button_control;
            rdata[`PB_SHORT_STAT_BIT] = short_press_status;
            rdata[`PB_LONG_STAT_BIT]  = long_press_status;
        end else begin
            rdata = 8'h00;
        end
    end

    assign status_read = rd.taken && (rd.addr == `ADDR_PUSH_BUTTON);

    // Buck target from range select and level code
    always_comb begin
        case (system_rail_control[`BUCK_RANGE_SELECT_HI:`BUCK_RANGE_SELECT_LO])
            `RANGE_LINEAR_LOW: begin
                next_buck_mv = `BUCK_BASE_LOW_MV
                    + 12'(system_rail_control[`SYS_CODE_HI:`SYS_CODE_LO]) * `STEP_MV;
            end
            `RANGE_LINEAR_HIGH: begin
                next_buck_mv = `BUCK_BASE_HIGH_MV
                    + 12'(system_rail_control[`SYS_CODE_HI:`SYS_CODE_LO]) * `STEP_MV;
            end
            `RANGE_MID_TABLE: begin
                next_buck_mv = table_mv(5'(system_rail_control[`SYS_CODE_HI:`SYS_CODE_LO])
                    + `MID_TABLE_OFFSET);
            end
            default: begin
                next_buck_mv = table_mv(5'(system_rail_control[`SYS_CODE_HI:`SYS_CODE_LO]));
            end
        endcase
    end

    // Buck outputs
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            BUCK_ENABLE    <= 1'b0;
            BUCK_PULL_LOW  <= 1'b1;
            BUCK_TARGET_MV <= `BUCK_BASE_HIGH_MV;
        end else begin
            BUCK_ENABLE    <= system_rail_control[`SYS_EN_BIT];
            BUCK_PULL_LOW  <= ~system_rail_control[`SYS_EN_BIT];
            BUCK_TARGET_MV <= next_buck_mv;
        end
    end

    // Aux level copied only while the output is held off
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            aux_level_applied <= 5'(`RESET_AUX_OUTPUT >> `AUX_CODE_LO);
        end else if (!aux_output_control[`AUX_EN_BIT] && !aux_pin_on) begin
            aux_level_applied <= aux_output_control[`AUX_CODE_HI:`AUX_CODE_LO];
        end
    end

    assign next_aux_mv = `AUX_BASE_MV + 12'(aux_level_applied) * `STEP_MV;

    // Auxiliary outputs
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            AUX_OUTPUT_ON    <= 1'b0;
            AUX_PASS_THROUGH <= 1'b0;
            AUX_TARGET_MV    <= `AUX_BASE_MV;
        end else begin
            AUX_OUTPUT_ON    <= aux_output_control[`AUX_EN_BIT] | aux_pin_on;
            AUX_PASS_THROUGH <= next_aux_mv > `AUX_PASS_LIMIT_MV;
            AUX_TARGET_MV    <= next_aux_mv;
        end
    end

    // Millisecond tick
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            tick_count <= 18'h00000;
            tick       <= 1'b0;
        end else if (tick_count == 18'(TICK_CYCLES - 1)) begin
            tick_count <= 18'h00000;
            tick       <= 1'b1;
        end else begin
            tick_count <= tick_count + 18'h00001;
            tick       <= 1'b0;
        end
    end

    // Press duration in milliseconds, saturating
    assign next_hold_ms = (hold_ms == `HOLD_MAX_MS) ? hold_ms : hold_ms + 14'h0001;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            hold_ms <= 14'h0000;
        end else if (!button_pressed) begin
            hold_ms <= 14'h0000;
        end else if (tick) begin
            hold_ms <= next_hold_ms;
        end
    end

    assign short_hit = button_pressed && tick && (next_hold_ms ==
        (push_button_control[`PB_SHORT_SEL_BIT] ? `SHORT_SLOW_MS : `SHORT_FAST_MS));
    assign long_hit  = button_pressed && tick && (next_hold_ms ==
        (push_button_control[`PB_LONG_SEL_BIT] ? `LONG_SLOW_MS : `LONG_FAST_MS));
    assign reset_due = button_pressed && !reset_issued
        && (hold_ms >= reset_hold_ms(push_button_control[`PB_RTIME_HI:`PB_RTIME_LO]))
        && (!aux_output_control[`AUX_QUAL_BIT] || vin_ok);

    // Wake status, set wins over read clear
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            short_press_status <= 1'b0;
            long_press_status  <= 1'b0;
        end else begin
            short_press_status <= short_hit | (short_press_status & ~status_read);
            long_press_status  <= long_hit | (long_press_status & ~status_read);
        end
    end

    // One reset pulse per press
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            reset_issued <= 1'b0;
            BUTTON_RESET <= 1'b0;
        end else begin
            BUTTON_RESET <= reset_due;
            if (!button_pressed) begin
                reset_issued <= 1'b0;
            end else if (reset_due) begin
                reset_issued <= 1'b1;
            end
        end
    end

    // Push-button mode outputs
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            RECOVER_TO_HIGH_Z    <= 1'b1;
            STATUS_PIN_AS_BUTTON <= 1'b0;
        end else begin
            RECOVER_TO_HIGH_Z    <= push_button_control[`PB_RECOVER_BIT];
            STATUS_PIN_AS_BUTTON <= push_button_control[`PB_PGMR_BIT];
        end
    end

endmodule
`default_nettype wire

/* serial_host.sv */
`default_nettype none
// Bus host with pulled-up data line
module serial_host (
    // Clock
    input  wire logic clock,
    // Bus pins
    input  wire logic sda_oe,
    output var  logic scl,
    output var  logic sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sda;
    // Pull-up
    assign sda = !(sda_oe || sda_low);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic half(input int n = 8);
        repeat (n) @(negedge clock);
    endtask
    // Start or repeated start, leaving the clock low
    task automatic start();
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
    endtask
    task automatic stop();
        half(4);
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask
    // Data changes mid low phase
    task automatic bit_io(input logic b, output logic r);
        half(4);
        sda_low = !b;
        half(4);
        scl = 1'b1;
        half();
        r = sda;
        scl = 1'b0;
    endtask
    // Byte MSB first, ninth bit released
    task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
        bit_io(1'b1, ack);
    endtask
endmodule
`default_nettype wire

/* output_rail_config_regs_props.sv */
`include "output_rail_defs.svh"
`default_nettype none
module rail_props (
    // Clock and reset
    input wire logic        CLOCK,
    input wire logic        RESETN,
    // Button pin
    input wire logic        PUSH_BUTTON_INPUT_N,
    // Rail and button outputs
    input wire logic        BUCK_ENABLE,
    input wire logic        BUCK_PULL_LOW,
    input wire logic [11:0] BUCK_TARGET_MV,
    input wire logic        AUX_OUTPUT_ON,
    input wire logic        AUX_PASS_THROUGH,
    input wire logic [11:0] AUX_TARGET_MV,
    input wire logic        BUTTON_RESET
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    // Pulse shape
    sequence one_pulse; BUTTON_RESET ##1 !BUTTON_RESET; endsequence
    sequence was_held; $past(PUSH_BUTTON_INPUT_N, 3) == 1'b0; endsequence
    a_buck_pull_low: assert property (BUCK_PULL_LOW != BUCK_ENABLE)
        else $error("pull-low wrong");
    a_buck_span: assert property (BUCK_TARGET_MV >= 12'h44c && BUCK_TARGET_MV <= 12'hce4)
        else $error("buck span");
    a_aux_step: assert property (AUX_TARGET_MV >= `AUX_BASE_MV
        && (AUX_TARGET_MV - `AUX_BASE_MV) % `STEP_MV == 12'h000) else $error("aux off grid");
    a_aux_pass: assert property (AUX_PASS_THROUGH == (AUX_TARGET_MV > `AUX_PASS_LIMIT_MV))
        else $error("pass-through wrong");
    a_aux_frozen: assert property (AUX_OUTPUT_ON && $past(AUX_OUTPUT_ON)
        && $past(AUX_OUTPUT_ON, 2) |-> $stable(AUX_TARGET_MV)) else $error("aux level moved");
    a_pulse_once: assert property (BUTTON_RESET |-> one_pulse)
        else $error("reset too long");
    a_press_first: assert property (BUTTON_RESET |-> was_held)
        else $error("reset unpressed");
    a_reset_buck: assert property ($rose(RESETN) |-> ##[1:2]
        (BUCK_ENABLE && BUCK_TARGET_MV == `BUCK_BASE_HIGH_MV)) else $error("buck reset wrong");
    a_reset_aux: assert property ($rose(RESETN) |-> ##[1:2]
        (!AUX_OUTPUT_ON && AUX_TARGET_MV == 12'h708)) else $error("aux reset wrong");
endmodule
bind output_rail_config_regs rail_props props (.CLOCK(CLOCK), .RESETN(RESETN),
    .PUSH_BUTTON_INPUT_N(PUSH_BUTTON_INPUT_N), .BUCK_ENABLE(BUCK_ENABLE),
    .BUCK_PULL_LOW(BUCK_PULL_LOW), .BUCK_TARGET_MV(BUCK_TARGET_MV), .AUX_OUTPUT_ON(AUX_OUTPUT_ON),
    .AUX_PASS_THROUGH(AUX_PASS_THROUGH), .AUX_TARGET_MV(AUX_TARGET_MV), .BUTTON_RESET(BUTTON_RESET));
`default_nettype wire

/* testbench.sv */
`include "output_rail_defs.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 2;
    logic        clock, resetn, scl, sda_oe, sda_low, btn_n, aux_pin, vin_ok;
    logic        buck_en, buck_low, aux_on, aux_pass, btn_rst;
    logic [11:0] buck_mv, aux_mv, exp_q[$], seen_q[$];
    logic [3:0]  code;
    logic [4:0]  acode[5] = '{5'h00, 5'h00, 5'h19, 5'h1a, 5'h1f};
    // Table ranges: 1.1, 1.2 V, then 1.25 V in 250/3 mV steps
    function automatic logic [11:0] tmv(input int i);
        return (i < 2) ? 12'(1100 + 100 * i) : 12'((3251 + 250 * i) / 3);
    endfunction
    int          fail_count, n_compared, cycles, cnt, seed;
    event        got;
    wire         sda = !(sda_oe || sda_low);
    output_rail_config_regs #(.TICK_CYCLES(T)) uut (.CLOCK(clock), .RESETN(resetn), .SCL(scl),
        .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe), .PUSH_BUTTON_INPUT_N(btn_n),
        .AUX_CONTROL_PIN(aux_pin), .VIN_VALID(vin_ok), .BUCK_ENABLE(buck_en),
        .BUCK_PULL_LOW(buck_low), .BUCK_TARGET_MV(buck_mv), .AUX_OUTPUT_ON(aux_on),
        .AUX_PASS_THROUGH(aux_pass), .AUX_TARGET_MV(aux_mv), .BUTTON_RESET(btn_rst),
        .RECOVER_TO_HIGH_Z(), .STATUS_PIN_AS_BUTTON());
    serial_host h (.clock(clock), .sda_oe(sda_oe), .scl(scl), .sda_low(sda_low));
    task automatic note(input logic [11:0] e, input logic [11:0] s);
        exp_q.push_back(e);
        seen_q.push_back(s);
        ->got;
    endtask
    task automatic check(input logic [11:0] s, input logic [11:0] e);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, s, e);
        end
    endtask
    // Monitor pairs each seen value with the oldest note
    always @(got) begin
        while (seen_q.size() > 0) check(seen_q.pop_front(), exp_q.pop_front());
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic       k;
        h.start();
        h.xfer({`DEVICE_ADDRESS, 1'b0}, r, k);
        h.xfer(a, r, k);
        h.xfer(d, r, k);
        h.stop();
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       k;
        h.start();
        h.xfer({`DEVICE_ADDRESS, 1'b0}, d, k);
        h.xfer(a, d, k);
        h.start();
        h.xfer({`DEVICE_ADDRESS, 1'b1}, d, k);
        h.xfer(8'hff, d, k);
        h.stop();
        note(12'(e), 12'(d));
    endtask
    // Press until reset pulse or limit
    task automatic hold(input int lim);
        cnt = 0;
        btn_n = 1'b0;
        while (btn_rst !== 1'b1 && cnt < lim) begin
            @(negedge clock);
            cnt++;
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = !clock;
    end
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 80000) begin
            fail_count++;
            wrap_up();
        end
    end
    initial begin
        seed = 32'he417;
        resetn = 1'b0;
        btn_n = 1'b1;
        aux_pin = 1'b0;
        vin_ok = 1'b0;
        repeat (16) @(negedge clock);
        resetn = 1'b1;
        rdc(`ADDR_SYSTEM_RAIL, `RESET_SYSTEM_RAIL);
        rdc(`ADDR_AUX_OUTPUT, `RESET_AUX_OUTPUT);
        rdc(`ADDR_PUSH_BUTTON, `RESET_PUSH_BUTTON);
        wr(8'h20, 8'h5a);
        rdc(8'h20, 8'h00);
        $display("done: reset values");
        // Buck rail, every range
        wr(`ADDR_SYSTEM_RAIL, 8'hff);
        rdc(`ADDR_SYSTEM_RAIL, 8'hfe);
        note(12'hce4, buck_mv);
        note(12'h001, 12'({buck_low, buck_en}));
        for (int s = 0; s < 8; s++) begin
            code = (s < 4) ? 4'($random(seed)) : 4'hf;
            wr(`ADDR_SYSTEM_RAIL, {1'b1, 2'(s), code, 1'b0});
            repeat (4) @(negedge clock);
            note(s[0] ? 12'(code) * `STEP_MV + (s[1] ? `BUCK_BASE_HIGH_MV : `BUCK_BASE_LOW_MV)
                : tmv(code + (s[1] ? 5 : 0)), buck_mv);
        end
        wr(`ADDR_SYSTEM_RAIL, 8'h2a);
        note(12'h002, 12'({buck_low, buck_en}));
        $display("done: buck rail");
        // Aux codes written while off
        acode[0] = 5'($random(seed));
        foreach (acode[i]) begin
            wr(`ADDR_AUX_OUTPUT, {1'b0, acode[i], 2'b00});
            repeat (4) @(negedge clock);
            note(`AUX_BASE_MV + 12'(acode[i]) * `STEP_MV, aux_mv);
            note(12'(acode[i] > 5'h19), 12'(aux_pass));
        end
        wr(`ADDR_AUX_OUTPUT, 8'h8c);
        note(12'h001, 12'(aux_on));
        note(12'hf3c, aux_mv);
        aux_pin = 1'b1;
        wr(`ADDR_AUX_OUTPUT, 8'h0c);
        note(12'h001, 12'(aux_on));
        note(12'hf3c, aux_mv);
        aux_pin = 1'b0;
        repeat (8) @(negedge clock);
        note(12'h000, 12'(aux_on));
        note(12'h44c, aux_mv);
        $display("done: aux output");
        // 5 s reset, wake status read twice
        wr(`ADDR_PUSH_BUTTON, 8'h60);
        hold(5000 * T + 40);
        note(12'h001, 12'(cnt >= 5000 * T && cnt <= 5000 * T + 12));
        btn_n = 1'b1;
        rdc(`ADDR_PUSH_BUTTON, 8'h63);
        rdc(`ADDR_PUSH_BUTTON, 8'h60);
        // Qualified 9 s reset
        wr(`ADDR_AUX_OUTPUT, 8'h0d);
        wr(`ADDR_PUSH_BUTTON, 8'h68);
        hold(9000 * T + 40);
        note(12'h000, 12'(btn_rst));
        vin_ok = 1'b1;
        hold(10);
        note(12'h001, 12'(btn_rst));
        btn_n = 1'b1;
        $display("done: push button");
        #1;
        wrap_up();
    end
endmodule
`default_nettype wire
